// *** design/imvc_pkg.sv ***
// shared constants for the interrupt mask, soft post and vector clear block
package imvc_pkg;

    // =====================================================================
    // register indices (byte address is four times the index)
    // =====================================================================
    localparam logic [7:0]  IMVC_IDX_POSTED     = 8'hda;
    localparam logic [7:0]  IMVC_IDX_MASK       = 8'he0;
    localparam logic [7:0]  IMVC_IDX_SWEN       = 8'he1;
    localparam logic [7:0]  IMVC_IDX_VC         = 8'he2;
    localparam logic [7:0]  IMVC_IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0]  IMVC_IDX_IRQ_MASK   = 8'hf1;
    localparam int          IMVC_ADDR_W         = 12;

    // =====================================================================
    // source bit positions
    // =====================================================================
    localparam int          IMVC_SRC_VMON   = 0;
    localparam int          IMVC_SRC_ANALOG = 1;
    localparam int          IMVC_SRC_TOUCH  = 2;
    localparam int          IMVC_SRC_TIMER  = 3;
    localparam int          IMVC_SRC_PIN    = 4;
    localparam int          IMVC_SRC_SPI    = 5;
    localparam int          IMVC_SRC_SLEEP  = 6;
    localparam int          IMVC_SRC_I2C    = 7;
    localparam int          IMVC_SWEN_BIT   = 0;

    // =====================================================================
    // vector address low bytes
    // =====================================================================
    localparam logic [7:0]  IMVC_VEC_NONE   = 8'h00;
    localparam logic [7:0]  IMVC_VEC_VMON   = 8'h04;
    localparam logic [7:0]  IMVC_VEC_ANALOG = 8'h08;
    localparam logic [7:0]  IMVC_VEC_TOUCH  = 8'h0c;
    localparam logic [7:0]  IMVC_VEC_TIMER  = 8'h10;
    localparam logic [7:0]  IMVC_VEC_PIN    = 8'h14;
    localparam logic [7:0]  IMVC_VEC_SPI    = 8'h18;
    localparam logic [7:0]  IMVC_VEC_I2C    = 8'h1c;
    localparam logic [7:0]  IMVC_VEC_SLEEP  = 8'h20;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic [7:0]  IMVC_RST_MASK   = 8'h00;
    localparam logic [7:0]  IMVC_RST_SWEN   = 8'h00;
    localparam logic [7:0]  IMVC_RST_POSTED = 8'h00;
    localparam logic [2:0]  IMVC_RST_STATUS = 3'h0;

    // =====================================================================
    // block interrupt event bits
    // =====================================================================
    localparam int          IMVC_EVT_NEW_PEND  = 0;
    localparam int          IMVC_EVT_CLEAR_ALL = 1;
    localparam int          IMVC_EVT_SERVICE   = 2;

    // =====================================================================
    // bus responses
    // =====================================================================
    localparam logic [1:0]  IMVC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  IMVC_RESP_SLVERR = 2'h2;

endpackage

// *** design/imvc_prio_enc.sv ***
// registered priority encoder from pending set to vector byte
`timescale 1ns/100ps
module imvc_prio_enc
    import imvc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] pending,
    output logic      [7:0] vector,
    output logic      [7:0] select
);

    // =====================================================================
    // fixed priority walk, highest first
    // =====================================================================
    function automatic logic [15:0] imvc_encode(input logic [7:0] p);
        logic [15:0] r;
        r = {8'h00, IMVC_VEC_NONE};
        if (p[IMVC_SRC_VMON]) begin                                   // [RQ12]
            r = {8'h01 << IMVC_SRC_VMON, IMVC_VEC_VMON};
        end else if (p[IMVC_SRC_ANALOG]) begin
            r = {8'h01 << IMVC_SRC_ANALOG, IMVC_VEC_ANALOG};
        end else if (p[IMVC_SRC_TOUCH]) begin
            r = {8'h01 << IMVC_SRC_TOUCH, IMVC_VEC_TOUCH};
        end else if (p[IMVC_SRC_TIMER]) begin
            r = {8'h01 << IMVC_SRC_TIMER, IMVC_VEC_TIMER};
        end else if (p[IMVC_SRC_PIN]) begin
            r = {8'h01 << IMVC_SRC_PIN, IMVC_VEC_PIN};
        end else if (p[IMVC_SRC_SPI]) begin
            r = {8'h01 << IMVC_SRC_SPI, IMVC_VEC_SPI};
        end else if (p[IMVC_SRC_I2C]) begin
            r = {8'h01 << IMVC_SRC_I2C, IMVC_VEC_I2C};
        end else if (p[IMVC_SRC_SLEEP]) begin
            r = {8'h01 << IMVC_SRC_SLEEP, IMVC_VEC_SLEEP};
        end
        return r;
    endfunction

    // re-evaluated every cycle so a later, higher request overtakes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vector <= IMVC_VEC_NONE;
            select <= 8'h00;
        end else begin
            {select, vector} <= imvc_encode(pending);                 // [RQ4] [RQ6]
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    default clocking enc_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    vec_none_a: assert property (pending == 8'h00 |=> vector == 8'h00) // [RQ7]
        else $error("vector not zero with nothing pending");
    vec_pin_i2c_a: assert property (                                  // [RQ6]
        pending[IMVC_SRC_PIN] && pending[IMVC_SRC_I2C] && pending[3:0] == 4'h0
        |=> vector == 8'h14)
        else $error("pin-change vector not chosen over i2c");
    vec_higher_a: assert property (                                   // [RQ4]
        pending[IMVC_SRC_VMON] |=> vector == 8'h04 && select == 8'h01)
        else $error("highest source not presented first");
    vec_sleep_low_a: assert property (                                // [RQ12]
        pending == 8'h40 |=> vector == 8'h20)
        else $error("sleep vector wrong");

endmodule

// *** design/imvc_irq_ctrl.sv ***
// interrupt mask, soft post and vector clear block with axi4-lite registers
//
// Overview of operation
// RQ1: mask zero blocks pending, posting still happens
// RQ2: each mask bit gates only its source
// RQ3: fixed source to bit position map
// RQ4: higher pending request presented before lower
// RQ5: soft post enable bit zero, rest reserved
// RQ6: vector read gives highest pending low byte
// RQ7: vector read zero when nothing pending
// RQ8: read harmless; service removes highest pending
// RQ9: any vector write clears posted and pending
// RQ10: enable selects write-zero clear or write-one post
// RQ11: posted register read shows posted requests
// RQ12: vectors four apart in fixed priority
// RQ13: event during clear-all stays posted
`timescale 1ns/100ps
module imvc_irq_ctrl
    import imvc_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // peripheral events, same clock
    input  wire logic [7:0]             src_event,
    // cpu core side
    input  wire logic                   cpu_ack,
    output logic                        cpu_irq,
    output logic      [7:0]             cpu_vector,
    output logic                        irq_out,
    // axi4-lite slave
    input  wire logic [IMVC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [IMVC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic      [31:0]            s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    // =====================================================================
    // declarations
    // =====================================================================
    logic [7:0]             irq_source_mask;
    logic                   soft_post_enable;
    logic [7:0]             posted_flag_reg;
    logic [7:0]             pending;
    logic [7:0]             pending_d;
    logic [7:0]             enc_vector;
    logic [7:0]             enc_select;
    logic [2:0]             irq_status;
    logic [2:0]             irq_mask;
    logic [2:0]             events;
    logic                   aw_held;
    logic                   w_held;
    logic [IMVC_ADDR_W-1:0] aw_addr_q;
    logic [7:0]             w_data_q;
    logic                   w_lane0_q;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   wr_do;
    logic                   wr_lane;
    logic                   next_aw_held;
    logic                   next_w_held;
    logic                   next_bvalid;
    logic                   next_rvalid;
    logic                   wr_posted;
    logic                   wr_vc;
    logic                   rd_status;
    logic [7:0]             post_set;
    logic [7:0]             post_clr;
    logic [7:0]             rd_byte;
    logic                   rd_hit;

    // =====================================================================
    // address decode
    // =====================================================================
    function automatic logic imvc_hit(input logic [IMVC_ADDR_W-1:0] a,
                                      input logic [7:0] idx);
        return (a[IMVC_ADDR_W-1:10] == 2'h0) && (a[9:2] == idx);
    endfunction

    function automatic logic imvc_mapped(input logic [IMVC_ADDR_W-1:0] a);
        return imvc_hit(a, IMVC_IDX_POSTED) || imvc_hit(a, IMVC_IDX_MASK)
            || imvc_hit(a, IMVC_IDX_SWEN) || imvc_hit(a, IMVC_IDX_VC)
            || imvc_hit(a, IMVC_IDX_IRQ_STATUS) || imvc_hit(a, IMVC_IDX_IRQ_MASK);
    endfunction

    // =====================================================================
    // write channels: address and data taken in either order
    // =====================================================================
    assign aw_take      = s_axi_awvalid && s_axi_awready;
    assign w_take       = s_axi_wvalid && s_axi_wready;
    assign wr_do        = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane      = wr_do && w_lane0_q;
    assign next_aw_held = (aw_held || aw_take) && !wr_do;
    assign next_w_held  = (w_held || w_take) && !wr_do;
    assign next_bvalid  = wr_do || (s_axi_bvalid && !s_axi_bready);
    assign wr_posted    = wr_lane && imvc_hit(aw_addr_q, IMVC_IDX_POSTED);
    assign wr_vc        = wr_lane && imvc_hit(aw_addr_q, IMVC_IDX_VC);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= IMVC_RESP_OKAY;
        end else begin
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (wr_do) begin
                s_axi_bresp <= imvc_mapped(aw_addr_q) ? IMVC_RESP_OKAY : IMVC_RESP_SLVERR;
            end
        end
    end

    // =====================================================================
    // control registers
    // =====================================================================
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_source_mask  <= IMVC_RST_MASK;
            soft_post_enable <= IMVC_RST_SWEN[IMVC_SWEN_BIT];
            irq_mask         <= IMVC_RST_STATUS;
        end else if (wr_lane) begin
            if (imvc_hit(aw_addr_q, IMVC_IDX_MASK)) begin
                irq_source_mask <= w_data_q;                           // [RQ3]
            end
            if (imvc_hit(aw_addr_q, IMVC_IDX_SWEN)) begin
                soft_post_enable <= w_data_q[IMVC_SWEN_BIT];           // [RQ5]
            end
            if (imvc_hit(aw_addr_q, IMVC_IDX_IRQ_MASK)) begin
                irq_mask <= w_data_q[2:0];
            end
        end
    end

    // =====================================================================
    // posted and pending requests
    // =====================================================================
    always_comb begin
        post_set = src_event;
        post_clr = 8'h00;
        if (wr_posted && soft_post_enable) begin
            post_set = post_set | w_data_q;                            // [RQ10]
        end
        if (wr_posted && !soft_post_enable) begin
            post_clr = ~w_data_q;                                      // [RQ10]
        end
        if (cpu_ack) begin
            post_clr = post_clr | enc_select;                          // [RQ8]
        end
        if (wr_vc) begin
            post_clr = 8'hff;                                          // [RQ9]
        end
    end

    // set after clear, so a fresh event survives any clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            posted_flag_reg <= IMVC_RST_POSTED;
        end else begin
            posted_flag_reg <= (posted_flag_reg & ~post_clr) | post_set; // [RQ13] [RQ1]
        end
    end

    assign pending = posted_flag_reg & irq_source_mask;                // [RQ1] [RQ2]

    imvc_prio_enc u_prio_enc (
        .clock   (clock),
        .rst_n   (rst_n),
        .pending (pending),
        .vector  (enc_vector),
        .select  (enc_select)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq    <= 1'b0;
            cpu_vector <= IMVC_VEC_NONE;
            pending_d  <= 8'h00;
        end else begin
            cpu_irq    <= (pending != 8'h00) && !wr_vc;
            cpu_vector <= enc_vector;
            pending_d  <= pending;
        end
    end

    // =====================================================================
    // block interrupt: sticky status, read clears, set wins
    // =====================================================================
    assign events[IMVC_EVT_NEW_PEND]  = (pending & ~pending_d) != 8'h00;
    assign events[IMVC_EVT_CLEAR_ALL] = wr_vc;
    assign events[IMVC_EVT_SERVICE]   = cpu_ack && (enc_select != 8'h00);
    assign rd_status = ar_take && imvc_hit(s_axi_araddr, IMVC_IDX_IRQ_STATUS);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= IMVC_RST_STATUS;
            irq_out    <= 1'b0;
        end else begin
            irq_status <= (rd_status ? 3'h0 : irq_status) | events;
            irq_out    <= (irq_status & irq_mask) != 3'h0;
        end
    end

    // =====================================================================
    // read channel
    // =====================================================================
    assign ar_take     = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (imvc_hit(s_axi_araddr, IMVC_IDX_POSTED)) begin
            rd_byte = posted_flag_reg;                                 // [RQ11]
        end else if (imvc_hit(s_axi_araddr, IMVC_IDX_MASK)) begin
            rd_byte = irq_source_mask;
        end else if (imvc_hit(s_axi_araddr, IMVC_IDX_SWEN)) begin
            rd_byte = {7'h00, soft_post_enable};                       // [RQ5]
        end else if (imvc_hit(s_axi_araddr, IMVC_IDX_VC)) begin
            rd_byte = enc_vector;                                      // [RQ6] [RQ7]
        end else if (imvc_hit(s_axi_araddr, IMVC_IDX_IRQ_STATUS)) begin
            rd_byte = {5'h00, irq_status};
        end else if (imvc_hit(s_axi_araddr, IMVC_IDX_IRQ_MASK)) begin
            rd_byte = {5'h00, irq_mask};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= IMVC_RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? IMVC_RESP_OKAY : IMVC_RESP_SLVERR;
            end
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    default clocking ctl_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence wr_vc_s;
        wr_vc ##1 s_axi_bvalid;
    endsequence

    sequence rd_vc_s;
        ar_take && imvc_hit(s_axi_araddr, IMVC_IDX_VC) ##1 s_axi_rvalid;
    endsequence

    mask_post_a: assert property (                                     // [RQ1]
        src_event[IMVC_SRC_PIN] && !irq_source_mask[IMVC_SRC_PIN] && !wr_lane
        |=> posted_flag_reg[IMVC_SRC_PIN] && !pending[IMVC_SRC_PIN])
        else $error("masked request not posted or became pending");
    mask_own_a: assert property (                                      // [RQ2]
        wr_lane && imvc_hit(aw_addr_q, IMVC_IDX_MASK)
        |=> irq_source_mask == $past(w_data_q))
        else $error("mask write disturbed other bits");
    clear_all_a: assert property (                                     // [RQ9]
        wr_vc && src_event == 8'h00
        |=> posted_flag_reg == 8'h00 && pending == 8'h00)
        else $error("vector write left requests");
    clear_keep_a: assert property (                                    // [RQ13]
        wr_vc |=> (posted_flag_reg & $past(src_event)) == $past(src_event))
        else $error("event lost in clear-all write");
    clear_resp_a: assert property (wr_vc_s |-> s_axi_bresp == IMVC_RESP_OKAY) // [RQ9]
        else $error("vector write not acknowledged okay");
    soft_post_a: assert property (                                     // [RQ10]
        wr_posted && soft_post_enable && w_data_q[IMVC_SRC_SPI]
        |=> posted_flag_reg[IMVC_SRC_SPI])
        else $error("soft post did not set request");
    soft_clear_a: assert property (                                    // [RQ10]
        wr_posted && !soft_post_enable && !w_data_q[IMVC_SRC_I2C]
        && !src_event[IMVC_SRC_I2C] |=> !posted_flag_reg[IMVC_SRC_I2C])
        else $error("write zero did not clear request");
    read_calm_a: assert property (                                     // [RQ8]
        rd_vc_s |-> $past(src_event) != 8'h00 || $past(cpu_ack) || $past(wr_lane)
        || posted_flag_reg == $past(posted_flag_reg))
        else $error("vector read changed requests");
    service_a: assert property (                                       // [RQ8]
        cpu_ack && enc_select != 8'h00 && (enc_select & src_event) == 8'h00
        |=> (posted_flag_reg & $past(enc_select)) == 8'h00)
        else $error("serviced request stayed posted");
    vec_read_a: assert property (                                      // [RQ6]
        ar_take && imvc_hit(s_axi_araddr, IMVC_IDX_VC)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(enc_vector)
        && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("vector read data wrong");
    swen_resv_a: assert property (                                     // [RQ5]
        ar_take && imvc_hit(s_axi_araddr, IMVC_IDX_SWEN)
        |=> s_axi_rdata[7:1] == 7'h00)
        else $error("reserved enable bits not zero");
    irq_level_a: assert property (
        (irq_status & irq_mask) != 3'h0 |=> irq_out)
        else $error("interrupt output low with unmasked status");

endmodule

// *** dv/imvc_cpu_model.sv ***
// cpu core model that services presented interrupt vectors
`timescale 1ns/100ps
module imvc_cpu_model
    import imvc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       take_en,
    input  wire logic       cpu_irq,
    input  wire logic [7:0] cpu_vector,
    output logic            cpu_ack,
    output logic      [7:0] last_vector
);
    logic [2:0] hold_off;
    // wait out the vector pipeline after each ack
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_ack     <= 1'b0;
            hold_off    <= 3'h0;
            last_vector <= IMVC_VEC_NONE;
        end else begin
            cpu_ack <= 1'b0;
            if (hold_off != 3'h0) begin
                hold_off <= hold_off - 3'h1;
            end else if (take_en && cpu_irq && cpu_vector != IMVC_VEC_NONE) begin
                cpu_ack     <= 1'b1;
                last_vector <= cpu_vector;
                hold_off    <= 3'h5;
            end
        end
    end
endmodule

// *** dv/irq_mask_vector_clear_bench.sv ***
// self-checking bench for the interrupt mask and vector clear block
`timescale 1ns/100ps
module irq_mask_vector_clear_bench
    import imvc_pkg::*;
;
    logic clock = 0, rst_n = 0, take_en = 0, ack, irq, irq_out;
    logic [7:0] src = 0, vec, last_vec;
    logic [11:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd_val;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] vt [8] = '{IMVC_VEC_VMON, IMVC_VEC_ANALOG, IMVC_VEC_TOUCH, IMVC_VEC_TIMER,
                           IMVC_VEC_PIN, IMVC_VEC_SPI, IMVC_VEC_SLEEP, IMVC_VEC_I2C};
    int n_mismatch = 0, compares = 0;
    imvc_irq_ctrl i_imvc_irq_ctrl (.clock(clock), .rst_n(rst_n), .src_event(src),
        .cpu_ack(ack), .cpu_irq(irq), .cpu_vector(vec), .irq_out(irq_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    imvc_cpu_model i_imvc_cpu_model (.clock(clock), .rst_n(rst_n), .take_en(take_en),
        .cpu_irq(irq), .cpu_vector(vec), .cpu_ack(ack), .last_vector(last_vec));
    // ==================================================================
    // bus tasks
    // ==================================================================
    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clock);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i);
        @(posedge clock);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd_val = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e, input string n);
        rd(i);
        chk(n, rd_val, {24'h0, e});
    endtask
    task automatic ev(input logic [7:0] b);
        @(posedge clock);
        src <= b;
        @(posedge clock);
        src <= 8'h00;
    endtask
    // ==================================================================
    // clock, watchdog and tests
    // ==================================================================
    initial forever #5 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rc(IMVC_IDX_MASK, 8'h00, "mask reset");
        rc(IMVC_IDX_SWEN, 8'h00, "enable reset");
        rc(IMVC_IDX_VC, IMVC_VEC_NONE, "vector idle");
        rc(8'h01, 8'h00, "unmapped data");
        chk("unmapped resp", resp, IMVC_RESP_SLVERR);
        ev(8'h90);
        rc(IMVC_IDX_POSTED, 8'h90, "posted masked");
        rc(IMVC_IDX_VC, IMVC_VEC_NONE, "vector masked");
        wr(IMVC_IDX_MASK, 8'h80);
        rc(IMVC_IDX_VC, IMVC_VEC_I2C, "vector one mask");
        wr(IMVC_IDX_MASK, 8'h91);
        rc(IMVC_IDX_VC, IMVC_VEC_PIN, "vector pin");
        rc(IMVC_IDX_VC, IMVC_VEC_PIN, "vector reread");
        ev(8'h01);
        rc(IMVC_IDX_VC, IMVC_VEC_VMON, "vector preempt");
        @(posedge clock);
        src <= 8'h20;
        wr(IMVC_IDX_VC, 8'h5a);
        src <= 8'h00;
        chk("clear resp", resp, IMVC_RESP_OKAY);
        rc(IMVC_IDX_POSTED, 8'h20, "clear all");
        wr(IMVC_IDX_SWEN, 8'h01);
        wr(IMVC_IDX_MASK, 8'hff);
        for (int i = 0; i < 8; i++) begin
            wr(IMVC_IDX_VC, 8'h00);
            wr(IMVC_IDX_POSTED, 8'h40 | (8'h01 << i));
            rc(IMVC_IDX_VC, vt[i], "vector priority");
        end
        wr(IMVC_IDX_POSTED, 8'h00);
        rc(IMVC_IDX_POSTED, 8'hc0, "zero ignored");
        wr(IMVC_IDX_SWEN, 8'h00);
        wr(IMVC_IDX_POSTED, 8'h7f);
        rc(IMVC_IDX_POSTED, 8'h40, "zero clears");
        ev(8'h14);
        repeat (3) @(posedge clock);
        chk("cpu irq", irq, 1'b1);
        chk("cpu vector", vec, IMVC_VEC_TOUCH);
        take_en <= 1'b1;
        repeat (30) @(posedge clock);
        take_en <= 1'b0;
        rc(IMVC_IDX_POSTED, 8'h00, "serviced");
        chk("last vector", last_vec, IMVC_VEC_SLEEP);
        wr(IMVC_IDX_IRQ_MASK, 8'h01);
        rd(IMVC_IDX_IRQ_STATUS);
        ev(8'h08);
        repeat (3) @(posedge clock);
        chk("irq raised", irq_out, 1'b1);
        rc(IMVC_IDX_IRQ_STATUS, 8'h01, "irq status");
        repeat (3) @(posedge clock);
        chk("irq cleared", irq_out, 1'b0);
        stop_test();
    end
endmodule
